// [verilog/dbm_top.sv]
// dram bank address mapper: bank decode, row/column multiplexing, strobes,
// refresh and self-refresh sequencing for four 32-bit dram banks
// assumes mem_req stays stable while mem_req_valid is high until mem_ack
`timescale 1ns/1ps
`include "dbm_defines.svh"

module dbm_top (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  mem_req_valid,
    input  wire dbm_pkg::dbm_req_s     mem_req,
    output logic                       mem_ack,
    output logic                       mem_err,
    input  wire logic [`DBM_PER_W-1:0] refresh_period_reg,
    input  wire logic                  self_refresh_enable,
    input  wire logic                  standby_req,
    output logic                       standby_ack,
    output dbm_pkg::dbm_dram_s         dram
);

    dbm_pkg::dbm_state_e   state_q;
    dbm_pkg::dbm_state_e   state_d;
    logic [`DBM_CNT_W-1:0] cnt_q;
    logic [`DBM_CNT_W-1:0] cnt_d;
    dbm_pkg::dbm_req_s     req_q;
    dbm_pkg::dbm_req_s     req_d;
    dbm_pkg::dbm_dram_s    dram_q;
    dbm_pkg::dbm_dram_s    dram_d;
    logic                  ack_q;
    logic                  ack_d;
    logic                  err_q;
    logic                  err_d;
    logic                  stby_q;
    logic                  stby_d;
    logic                  refresh_req;
    logic                  refresh_done;
    logic [1:0]            bank;

    dbm_refresh u_refresh (
        .sys_clk            (sys_clk),
        .rstn               (rstn),
        .refresh_period_reg (refresh_period_reg),
        .refresh_done       (refresh_done),
        .refresh_req        (refresh_req)
    );

    // fixed 256 MB window per bank, tag C plus bank number in the top nibble
    assign bank = mem_req.addr[`DBM_BANK_HI:`DBM_BANK_LO];

    always_comb begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        req_d        = req_q;
        dram_d       = dram_q;
        ack_d        = 1'b0;
        err_d        = 1'b0;
        stby_d       = stby_q;
        refresh_done = 1'b0;
        unique case (state_q)
            dbm_pkg::DBM_IDLE: begin
                // standby only from idle so no dram cycle is cut short
                if (standby_req) begin
                    stby_d = 1'b1;
                    if (self_refresh_enable) begin
                        dram_d.cas_n = '0;
                        state_d      = dbm_pkg::DBM_SCAS;
                    end else begin
                        state_d = dbm_pkg::DBM_STBY;
                    end
                end else if (refresh_req) begin
                    refresh_done = 1'b1;
                    dram_d.cas_n = '0;
                    state_d      = dbm_pkg::DBM_RCAS;
                end else if (mem_req_valid && !ack_q) begin
                    // a request whose answer is still showing is not taken twice
                    if (mem_req.addr[`DBM_WIN_HI:`DBM_WIN_LO] != `DBM_WIN_TAG) begin
                        ack_d = 1'b1;
                        err_d = 1'b1;
                    end else begin
                        // upper bits beyond the fitted device are simply never
                        // driven as strobes, so small parts alias in the window
                        req_d              = mem_req;
                        dram_d.mux_addr    = dbm_pkg::dbm_row_of(mem_req.addr);
                        dram_d.ras_n       = ~(`DBM_NBANK'(1) << bank);
                        dram_d.we_n        = ~mem_req.write;
                        cnt_d              = `DBM_CNT_W'(`DBM_T_RCD_CYC - 1);
                        state_d            = dbm_pkg::DBM_ROW;
                    end
                end
            end
            dbm_pkg::DBM_ROW: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    dram_d.mux_addr = dbm_pkg::dbm_col_of(req_q.addr);
                    dram_d.cas_n    = ~req_q.be;
                    cnt_d           = `DBM_CNT_W'(`DBM_T_CAS_CYC - 1);
                    state_d         = dbm_pkg::DBM_COL;
                end
            end
            dbm_pkg::DBM_COL: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    dram_d.ras_n = '1;
                    dram_d.cas_n = '1;
                    dram_d.we_n  = 1'b1;
                    ack_d        = 1'b1;
                    cnt_d        = `DBM_CNT_W'(`DBM_T_RP_CYC - 1);
                    state_d      = dbm_pkg::DBM_PRE;
                end
            end
            dbm_pkg::DBM_PRE: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    state_d = dbm_pkg::DBM_IDLE;
                end
            end
            dbm_pkg::DBM_RCAS: begin
                // cas before ras refresh across all banks
                dram_d.ras_n = '0;
                cnt_d        = `DBM_CNT_W'(`DBM_T_RAS_CYC - 1);
                state_d      = dbm_pkg::DBM_RRAS;
            end
            dbm_pkg::DBM_RRAS: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    dram_d.ras_n = '1;
                    dram_d.cas_n = '1;
                    cnt_d        = `DBM_CNT_W'(`DBM_T_RP_CYC - 1);
                    state_d      = dbm_pkg::DBM_PRE;
                end
            end
            dbm_pkg::DBM_SCAS: begin
                dram_d.ras_n = '0;
                state_d      = dbm_pkg::DBM_SELF;
            end
            dbm_pkg::DBM_SELF: begin
                if (!standby_req) begin
                    dram_d.ras_n = '1;
                    dram_d.cas_n = '1;
                    stby_d       = 1'b0;
                    cnt_d        = `DBM_CNT_W'(`DBM_T_RP_CYC - 1);
                    state_d      = dbm_pkg::DBM_PRE;
                end
            end
            dbm_pkg::DBM_STBY: begin
                if (!standby_req) begin
                    stby_d  = 1'b0;
                    state_d = dbm_pkg::DBM_IDLE;
                end
            end
            default: begin
                state_d = dbm_pkg::DBM_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q         <= dbm_pkg::DBM_IDLE;
            cnt_q           <= '0;
            req_q           <= '0;
            dram_q.mux_addr <= '0;
            dram_q.ras_n    <= '1;
            dram_q.cas_n    <= '1;
            dram_q.we_n     <= 1'b1;
            ack_q           <= 1'b0;
            err_q           <= 1'b0;
            stby_q          <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            req_q   <= req_d;
            dram_q  <= dram_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
            stby_q  <= stby_d;
        end
    end

    assign dram        = dram_q;
    assign mem_ack     = ack_q;
    assign mem_err     = err_q;
    assign standby_ack = stby_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic in_access;
    assign in_access = state_q inside {dbm_pkg::DBM_ROW, dbm_pkg::DBM_COL};

    a_one_bank_ras: assert property (
        in_access |-> $countones(~dram.ras_n) == 1)
        else $error("more than one bank row strobe during an access");

    a_bank_window: assert property (
        (state_q == dbm_pkg::DBM_IDLE && !standby_req && !refresh_req && mem_req_valid
         && !mem_ack && mem_req.addr[31:30] == 2'h3)
        |=> dram.ras_n == ~(4'h1 << $past(mem_req.addr[29:28])))
        else $error("row strobe does not follow bank nibble");

    a_outside_err: assert property (
        (state_q == dbm_pkg::DBM_IDLE && !standby_req && !refresh_req && mem_req_valid
         && !mem_ack && mem_req.addr[31:30] != 2'h3) |=> mem_ack && mem_err)
        else $error("address outside dram windows not refused");

    a_row_bits: assert property (
        $rose(|(~dram.ras_n)) && state_q == dbm_pkg::DBM_ROW
        |-> dram.mux_addr[7:0] == req_q.addr[17:10])
        else $error("row phase low bits wrong");

    a_col_bits: assert property (
        (state_q == dbm_pkg::DBM_COL && $past(state_q) == dbm_pkg::DBM_ROW)
        |-> dram.mux_addr[12] == req_q.addr[27] && dram.mux_addr[8] == req_q.addr[19]
            && dram.mux_addr[7:0] == req_q.addr[9:2])
        else $error("column phase bits wrong");

    a_row_then_col: assert property (
        (state_q == dbm_pkg::DBM_COL && $past(state_q) == dbm_pkg::DBM_ROW)
        |-> $past(dram.cas_n, 1) == 4'hF && dram.cas_n == ~req_q.be
            && $past(dram.ras_n, 1) == dram.ras_n)
        else $error("column strobes not after row strobe");

    a_refresh_cbr: assert property (
        state_q == dbm_pkg::DBM_RCAS |-> dram.cas_n == 4'h0 && dram.ras_n == 4'hF
        ##1 dram.ras_n == 4'h0 && dram.cas_n == 4'h0)
        else $error("refresh not cas before ras");

    a_self_enable: assert property (
        $rose(state_q == dbm_pkg::DBM_SCAS) |-> $past(self_refresh_enable) && standby_ack)
        else $error("self refresh without enable");

    a_no_cut_cycle: assert property (
        (in_access && standby_req) |=> state_q != dbm_pkg::DBM_STBY
        && state_q != dbm_pkg::DBM_SCAS)
        else $error("standby cut a dram cycle short");

    // acknowledge and error flags, strobe levels per phase and the remaining mux bits
    a_ack_pulse: assert property (
        mem_ack |=> !mem_ack)
        else $error("acknowledge longer than one cycle");

    a_err_needs_ack: assert property (
        mem_err |-> mem_ack)
        else $error("error flag without acknowledge");

    a_refused_no_ras: assert property (
        mem_err |-> dram.ras_n == 4'hF)
        else $error("row strobe on refused address");

    a_row_cas_high: assert property (
        state_q == dbm_pkg::DBM_ROW |-> dram.cas_n == 4'hF)
        else $error("column strobe during row phase");

    a_row_hi_bits: assert property (
        (state_q == dbm_pkg::DBM_ROW && $past(state_q) == dbm_pkg::DBM_IDLE)
        |-> dram.mux_addr[12:8] == {req_q.addr[26], req_q.addr[24], req_q.addr[22],
                                    req_q.addr[20], req_q.addr[18]})
        else $error("row phase high bits wrong");

    a_col_mid_bits: assert property (
        (state_q == dbm_pkg::DBM_COL && $past(state_q) == dbm_pkg::DBM_ROW)
        |-> dram.mux_addr[11:9] == {req_q.addr[25], req_q.addr[23], req_q.addr[21]})
        else $error("column phase middle bits wrong");

    a_ras_through_col: assert property (
        state_q == dbm_pkg::DBM_COL |-> dram.ras_n == $past(dram.ras_n))
        else $error("row strobe moved during column phase");

    a_lane_select: assert property (
        state_q == dbm_pkg::DBM_COL |-> dram.cas_n == ~req_q.be)
        else $error("column strobes do not follow byte lanes");

    a_prech_strobes: assert property (
        state_q == dbm_pkg::DBM_PRE |-> dram.ras_n == 4'hF && dram.cas_n == 4'hF)
        else $error("strobes low during precharge");

    a_idle_strobes_high: assert property (
        state_q == dbm_pkg::DBM_IDLE
        |-> dram.ras_n == 4'hF && dram.cas_n == 4'hF && dram.we_n)
        else $error("strobes low while idle");

    a_refresh_all_banks: assert property (
        state_q == dbm_pkg::DBM_RRAS |-> dram.ras_n == 4'h0 && dram.cas_n == 4'h0)
        else $error("refresh does not strobe all banks");

    a_self_hold: assert property (
        state_q == dbm_pkg::DBM_SELF
        |-> dram.ras_n == 4'h0 && dram.cas_n == 4'h0 && standby_ack)
        else $error("self refresh strobes not held");

    a_stby_plain: assert property (
        state_q == dbm_pkg::DBM_STBY
        |-> dram.ras_n == 4'hF && dram.cas_n == 4'hF && standby_ack)
        else $error("plain standby drives strobes");

    c_access:  cover property (state_q == dbm_pkg::DBM_COL ##1 mem_ack);
    c_plain:   cover property (state_q == dbm_pkg::DBM_STBY ##1 !standby_req);
    c_refresh: cover property (state_q == dbm_pkg::DBM_RRAS);
    c_self:    cover property (state_q == dbm_pkg::DBM_SELF ##1 !standby_req);
    c_error:   cover property (mem_err);

endmodule : dbm_top

// [include/dbm_defines.svh]
// constants for the dram bank address mapper: decode, timing and refresh counts
// assumes a 100 MHz sys_clk and a 32-bit physical address from the memory bus
// Operation
// - Up to four banks of 32-bit DRAM are driven directly, each bank up to 256 Mb.
// - There is one row strobe per bank and one column strobe per byte lane.
// - Device size is not configurable, so banks sit in fixed windows 256 MBytes apart.
// - Unused upper address bits are ignored, so small devices alias through the window.
// - One fixed row/column assignment serves every square DRAM from 4 Mbit to 1 Gbit.
// - Mux bits 0-7 carry A2-A9 in the column phase and A10-A17 in the row phase.
// - Mux bits 8-12 carry A19,A21,A23,A25,A27 as column and A18,A20,A22,A24,A26 as row.
// - The top nibble of a bank window is hex C plus the bank number.
// - Non-square devices leave the bank split into discontiguous segments.
// - Every contiguous populated segment is at least 1 Mb long.
// - A refresh counter issues refresh cycles at the programmed refresh period; none are issued during standby.
// - Standby enters self-refresh when enabled, never cutting a DRAM cycle short.
`ifndef DBM_DEFINES_SVH
`define DBM_DEFINES_SVH

`define DBM_NBANK        4
`define DBM_NLANE        4
`define DBM_MUX_W        13
`define DBM_WIN_HI       31
`define DBM_WIN_LO       30
`define DBM_WIN_TAG      2'h3
`define DBM_BANK_HI      29
`define DBM_BANK_LO      28
`define DBM_LO_COL_BASE  2
`define DBM_LO_ROW_BASE  10
`define DBM_HI_ROW_BASE  18
`define DBM_HI_COL_BASE  19
`define DBM_LO_BITS      8

`define DBM_CLK_NS       10
`define DBM_T_RCD_NS     20
`define DBM_T_CAS_NS     20
`define DBM_T_RAS_NS     50
`define DBM_T_RP_NS      30
`define DBM_NS2CYC(t)    ((((t) + `DBM_CLK_NS - 1) / `DBM_CLK_NS) > 0 ? \
                          (((t) + `DBM_CLK_NS - 1) / `DBM_CLK_NS) : 1)
`define DBM_T_RCD_CYC    `DBM_NS2CYC(`DBM_T_RCD_NS)
`define DBM_T_CAS_CYC    `DBM_NS2CYC(`DBM_T_CAS_NS)
`define DBM_T_RAS_CYC    `DBM_NS2CYC(`DBM_T_RAS_NS)
`define DBM_T_RP_CYC     `DBM_NS2CYC(`DBM_T_RP_NS)
`define DBM_CNT_W        4

`define DBM_PER_W        8
`define DBM_REF_UNIT_LG  4
`define DBM_REF_CNT_W    12

`endif

// [include/dbm_pkg.sv]
// types shared by the dram bank address mapper
// assumes dbm_defines.svh is on the include path
`include "dbm_defines.svh"

package dbm_pkg;

    typedef struct packed {
        logic [31:0]              addr;
        logic                     write;
        logic [`DBM_NLANE-1:0]    be;
    } dbm_req_s;

    typedef struct packed {
        logic [`DBM_MUX_W-1:0]    mux_addr;
        logic [`DBM_NBANK-1:0]    ras_n;
        logic [`DBM_NLANE-1:0]    cas_n;
        logic                     we_n;
    } dbm_dram_s;

    typedef enum logic [3:0] {
        DBM_IDLE,
        DBM_ROW,
        DBM_COL,
        DBM_PRE,
        DBM_RCAS,
        DBM_RRAS,
        DBM_SCAS,
        DBM_SELF,
        DBM_STBY
    } dbm_state_e;

    typedef logic [`DBM_MUX_W-1:0] dbm_mux_t;

    function automatic dbm_mux_t dbm_row_of(input logic [31:0] a);
        dbm_mux_t r;
        r = '0;
        for (int k = 0; k < `DBM_MUX_W; k++) begin
            if (k < `DBM_LO_BITS) begin
                r[k] = a[`DBM_LO_ROW_BASE + k];
            end else begin
                r[k] = a[`DBM_HI_ROW_BASE + 2 * (k - `DBM_LO_BITS)];
            end
        end
        return r;
    endfunction : dbm_row_of

    function automatic dbm_mux_t dbm_col_of(input logic [31:0] a);
        dbm_mux_t c;
        c = '0;
        for (int k = 0; k < `DBM_MUX_W; k++) begin
            if (k < `DBM_LO_BITS) begin
                c[k] = a[`DBM_LO_COL_BASE + k];
            end else begin
                c[k] = a[`DBM_HI_COL_BASE + 2 * (k - `DBM_LO_BITS)];
            end
        end
        return c;
    endfunction : dbm_col_of

endpackage : dbm_pkg

// [verilog/dbm_refresh.sv]
// refresh period counter: raises a sticky refresh request every period
// assumes the sequencer pulses refresh_done when it starts a refresh cycle
`timescale 1ns/1ps
`include "dbm_defines.svh"

module dbm_refresh (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic [`DBM_PER_W-1:0] refresh_period_reg,
    input  wire logic                  refresh_done,
    output logic                       refresh_req
);

    logic [`DBM_REF_CNT_W-1:0] cnt_q;
    logic [`DBM_REF_CNT_W-1:0] cnt_d;
    logic                      pend_q;
    logic                      pend_d;
    logic                      tick;

    always_comb begin
        tick  = 1'b0;
        cnt_d = cnt_q;
        if (refresh_period_reg == '0) begin
            cnt_d = '0;
        end else if (cnt_q == '0) begin
            tick  = 1'b1;
            cnt_d = {refresh_period_reg, {`DBM_REF_UNIT_LG{1'b0}}} - 1'b1;
        end else begin
            cnt_d = cnt_q - 1'b1;
        end
        // a tick in the same cycle as the clear keeps the request
        pend_d = tick | (pend_q & ~refresh_done);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= '0;
            pend_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            pend_q <= pend_d;
        end
    end

    assign refresh_req = pend_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_tick_sets_req: assert property (
        (refresh_period_reg != '0 && cnt_q == '0) |=> refresh_req)
        else $error("refresh request missing after period expiry");

endmodule : dbm_refresh

// [test/dbm_dram_model.sv]
// dram bank model: watches strobes and latches what each phase carries
// assumes registered strobes from dbm_top, sampled at the rising edge
`timescale 1ns/1ps

module dbm_dram_model (
    input  wire logic               sys_clk,
    input  wire dbm_pkg::dbm_dram_s dram,
    output dbm_pkg::dbm_mux_t       row_seen,
    output dbm_pkg::dbm_mux_t       col_seen,
    output logic [3:0]              ras_seen,
    output logic [3:0]              lanes_seen,
    output logic                    we_n_seen,
    output int                      acc_cnt,
    output int                      ref_cnt
);
    logic [3:0] ras_prev = 4'hF;
    logic [3:0] cas_prev = 4'hF;
    int         acc_q = 0;
    int         ref_q = 0;

    assign acc_cnt = acc_q;
    assign ref_cnt = ref_q;

    // two x16 parts share one row strobe, so a bank is four byte lanes
    always @(posedge sys_clk) begin
        if (((ras_prev & ~dram.ras_n) != 4'h0) && (dram.cas_n == 4'hF)) begin
            row_seen <= dram.mux_addr;
            ras_seen <= dram.ras_n;
        end
        if (((cas_prev & ~dram.cas_n) != 4'h0) && (dram.ras_n != 4'hF)) begin
            col_seen   <= dram.mux_addr;
            lanes_seen <= ~dram.cas_n;
            we_n_seen  <= dram.we_n;
            acc_q      <= acc_q + 1;
        end
        // column strobe before row strobe is a refresh
        if (((ras_prev & ~dram.ras_n) != 4'h0) && (dram.cas_n != 4'hF)) begin
            ref_q <= ref_q + 1;
        end
        ras_prev <= dram.ras_n;
        cas_prev <= dram.cas_n;
    end
endmodule : dbm_dram_model

// [test/dbm_top_tb.sv]
// self-checking bench for dbm_top with a strobe-watching dram model
// assumes dbm_pkg compiled first and dbm_defines.svh on the include path
`timescale 1ns/1ps
`include "dbm_defines.svh"

module dbm_top_tb;
    logic                  sys_clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  mem_req_valid = 1'b0;
    dbm_pkg::dbm_req_s     mem_req = '0;
    logic                  mem_ack;
    logic                  mem_err;
    logic [`DBM_PER_W-1:0] refresh_period_reg = '0;
    logic                  self_refresh_enable = 1'b0;
    logic                  standby_req = 1'b0;
    logic                  standby_ack;
    dbm_pkg::dbm_dram_s    dram;
    dbm_pkg::dbm_mux_t     row_seen;
    dbm_pkg::dbm_mux_t     col_seen;
    logic [3:0]            ras_seen;
    logic [3:0]            lanes_seen;
    logic                  we_n_seen;
    int                    acc_cnt;
    int                    ref_cnt;
    int                    err_total = 0;
    int                    comparisons = 0;
    int                    cyc = 0;

    always #5 sys_clk = ~sys_clk;

    dbm_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .mem_req_valid(mem_req_valid),
        .mem_req(mem_req), .mem_ack(mem_ack), .mem_err(mem_err),
        .refresh_period_reg(refresh_period_reg), .self_refresh_enable(self_refresh_enable),
        .standby_req(standby_req), .standby_ack(standby_ack), .dram(dram));

    dbm_dram_model i_mem (.sys_clk(sys_clk), .dram(dram), .row_seen(row_seen),
        .col_seen(col_seen), .ras_seen(ras_seen), .lanes_seen(lanes_seen),
        .we_n_seen(we_n_seen), .acc_cnt(acc_cnt), .ref_cnt(ref_cnt));

    task automatic stop_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    function automatic dbm_pkg::dbm_mux_t exp_mux(input logic [31:0] a, input logic col);
        dbm_pkg::dbm_mux_t m;
        for (int k = 0; k < 13; k++) begin
            if (k < 8) m[k] = col ? a[2 + k] : a[10 + k];
            else m[k] = col ? a[19 + 2 * (k - 8)] : a[18 + 2 * (k - 8)];
        end
        return m;
    endfunction : exp_mux

    // drives one request and holds it until the acknowledge is sampled
    task automatic access(input logic [31:0] a, input logic wr, input logic [3:0] be);
        int n;
        n = 0;
        mem_req       <= '{addr: a, write: wr, be: be};
        mem_req_valid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (mem_ack !== 1'b1 && n < 40);
        chk(n < 40, 1, "no acknowledge");
        mem_req_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : access

    task automatic t_reset;
        chk(dram.ras_n, 4'hF, "ras at reset");
        chk(dram.cas_n, 4'hF, "cas at reset");
        chk({dram.we_n, dram.mux_addr}, 32'h0000_2000, "we/mux at reset");
        chk({mem_ack, mem_err, standby_ack}, 0, "acks at reset");
    endtask : t_reset

    task automatic t_maps;
        logic [31:0] ad [6];
        logic [3:0]  bl [6];
        int          a0;
        ad = '{32'hC000_0404, 32'hD555_5554, 32'hEAAA_AAA8, 32'hF3C3_C3C4,
               32'hC000_0407, 32'hFFFF_FFFC};
        bl = '{4'hF, 4'h1, 4'h6, 4'h8, 4'h3, 4'hC};
        for (int i = 0; i < 6; i++) begin
            a0 = acc_cnt;
            access(ad[i], i[0], bl[i]);
            chk(mem_err, 0, "error on good address");
            chk(acc_cnt - a0, 1, "strobe cycles");
            chk(ras_seen, 4'(~(4'h1 << ad[i][29:28])), "bank row strobe");
            chk(row_seen, exp_mux(ad[i], 1'b0), "row phase");
            chk(col_seen, exp_mux(ad[i], 1'b1), "column phase");
            chk(lanes_seen, bl[i], "byte lanes");
            chk(we_n_seen, !i[0], "write strobe");
        end
    endtask : t_maps

    task automatic t_refused;
        int a0;
        int n;
        a0 = acc_cnt;
        n = 0;
        mem_req       <= '{addr: 32'hB000_0000, write: 1'b0, be: 4'hF};
        mem_req_valid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (mem_ack !== 1'b1 && n < 40);
        chk(mem_ack & mem_err, 1, "refusal");
        chk(n, 2, "refusal latency");
        mem_req_valid <= 1'b0;
        @(posedge sys_clk);
        chk(mem_ack, 0, "single refusal");
        repeat (4) @(posedge sys_clk);
        chk(acc_cnt - a0, 0, "strobes on refused address");
    endtask : t_refused

    task automatic t_refresh;
        int r0;
        r0 = ref_cnt;
        refresh_period_reg <= 8'h01;
        repeat (160) @(posedge sys_clk);
        refresh_period_reg <= 8'h00;
        repeat (20) @(posedge sys_clk);
        chk((ref_cnt - r0 >= 9) && (ref_cnt - r0 <= 12), 1, "refresh rate");
    endtask : t_refresh

    // standby raised while an access runs must not cut it short
    task automatic t_standby(input logic sre);
        int a0;
        int r0;
        int n;
        a0 = acc_cnt;
        r0 = ref_cnt;
        n = 0;
        self_refresh_enable <= sre;
        mem_req       <= '{addr: 32'hE000_1000, write: 1'b1, be: 4'hF};
        mem_req_valid <= 1'b1;
        @(posedge sys_clk);
        standby_req <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (mem_ack !== 1'b1 && n < 40);
        mem_req_valid <= 1'b0;
        chk(acc_cnt - a0, 1, "access finished before standby");
        repeat (12) @(posedge sys_clk);
        chk(standby_ack, 1, "standby entered");
        chk(dram.ras_n | dram.cas_n, sre ? 4'h0 : 4'hF, "self-refresh strobes");
        chk(ref_cnt - r0, sre, "self-refresh entry");
        standby_req <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({standby_ack, dram.ras_n, dram.cas_n}, 32'h0000_00FF, "standby left");
    endtask : t_standby

    initial begin
        repeat (2) @(posedge sys_clk);
        t_reset();
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_maps();
        t_refused();
        t_refresh();
        t_standby(1'b1);
        t_standby(1'b0);
        stop_test();
    end
endmodule : dbm_top_tb
